// ---- core_model.sv ----
`default_nettype none
// stands in for both core subsystems: raises their reset requests on command
module core_model
  import reset_dist_pkg::*;
(
  input  wire logic pclk,
  output logic      app_lockup,
  output logic      app_soft_req,
  output logic      sysoff_wake,
  output logic      app_wdt_timeout,
  output logic      net_lockup,
  output logic      net_soft_req,
  output logic      net_wdt_timeout,
  output logic      pin_reset_n,
  output logic      brownout_det
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [NSRC-1:0] req_r;

  initial req_r = '0;
  // one request line per source except hold-off; the pin is active low, so it idles high
  assign app_lockup      = req_r[S_APP_LOCKUP];
  assign app_soft_req    = req_r[S_APP_SOFT];
  assign sysoff_wake     = req_r[S_WAKE];
  assign app_wdt_timeout = req_r[S_APP_WDT];
  assign net_lockup      = req_r[S_NET_LOCKUP];
  assign net_soft_req    = req_r[S_NET_SOFT];
  assign net_wdt_timeout = req_r[S_NET_WDT];
  assign pin_reset_n     = ~req_r[S_PIN];
  assign brownout_det    = req_r[S_BROWNOUT];

  // a one-cycle request, changed only right after a rising edge
  task automatic pulse(input int src);
    @(posedge pclk);
    req_r <= NSRC'(1) << src;
    @(posedge pclk);
    req_r <= '0;
  endtask : pulse
endmodule : core_model
`default_nettype wire

// ---- reset_dist_pkg.sv ----
`default_nettype none
package reset_dist_pkg;
  // register byte offsets
  localparam logic [11:0] OFF_APP_CAUSE = 12'h000;
  localparam logic [11:0] OFF_NET_CAUSE = 12'h004;
  localparam logic [11:0] OFF_HOLD_OFF  = 12'h008;
  localparam logic [11:0] OFF_GPREG     = 12'h00c;
  localparam logic [11:0] OFF_STATUS    = 12'h010;
  localparam logic [31:0] RESET_ZERO    = 32'h0000_0000;

  // reset-cause record bit positions (both records share the low ones)
  localparam int CB_PIN     = 0;
  localparam int CB_DOG     = 1;
  localparam int CB_SREQ    = 3;
  localparam int CB_LOCKUP  = 4;
  localparam int CB_OFF     = 5;
  localparam int CB_LSREQ   = 16;
  localparam int CB_LLOCKUP = 17;
  localparam int CB_LDOG    = 18;
  localparam int CB_HOLDOFF = 24;

  // status register fields
  localparam int ST_BUSY    = 0;
  localparam int ST_DEBUG   = 1;
  localparam int ST_SYSOFF  = 2;
  localparam int ST_HOLD    = 3;
  localparam int ST_TGT_LSB = 16;

  // reset sources
  localparam int NSRC          = 10;
  localparam int S_APP_LOCKUP  = 0;
  localparam int S_APP_SOFT    = 1;
  localparam int S_WAKE        = 2;
  localparam int S_APP_WDT     = 3;
  localparam int S_PIN         = 4;
  localparam int S_BROWNOUT    = 5;
  localparam int S_HOLDOFF     = 6;
  localparam int S_NET_LOCKUP  = 7;
  localparam int S_NET_SOFT    = 8;
  localparam int S_NET_WDT     = 9;

  // reset targets, one bit each
  localparam int NTGT          = 14;
  localparam int T_APP_CPU     = 0;
  localparam int T_NET_CPU     = 1;
  localparam int T_APP_DBG     = 2;
  localparam int T_NET_DBG     = 3;
  localparam int T_APP_WDT     = 4;
  localparam int T_NET_WDT     = 5;
  localparam int T_APP_PERIPH  = 6;
  localparam int T_SPU         = 7;
  localparam int T_APP_GPIO    = 8;
  localparam int T_GPIO_OWNER  = 9;
  localparam int T_REGUL       = 10;
  localparam int T_GPREG       = 11;
  localparam int T_NET_PERIPH  = 12;
  localparam int T_NET_GPIO    = 13;

  // reset pulse timing
  localparam int CLK_NS        = 40;
  localparam int RST_PULSE_NS  = 200;
  localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W         = 4;
  localparam logic [CNT_W-1:0] PULSE_LOAD = CNT_W'(RST_PULSE_CYC);
  localparam logic [CNT_W-1:0] CNT_LAST   = 4'h1;
  localparam int GPREG_W       = 8;
endpackage : reset_dist_pkg
`default_nettype wire

// ---- reset_distributor.sv ----
// Local design decisions: the register offsets and the APB interface to the registers.
`default_nettype none
// Notes on behaviour
// - retained record and retention registers survive resets except those that clear them.
// - any application reset forces network hold-off and flags it in the network record.
// - in System OFF the application watchdog stops and application lockup cannot reset.
// - network watchdog stops and network lockup ignored in System OFF or hold-off.
// - in debug mode no source resets either core's debug logic.
// - in debug mode a lockup in either core causes no reset.
// - application lockup or soft reset resets application CPU and network core only.
// - wakeup resets application CPU, network core, debug and watchdog; record kept.
// - app watchdog resets all core targets but network debug; pin, brownout, power-on reset all; last two clear record.
// - hold-off control alone resets only the network core.
// - RAM is never actively cleared by any reset.
// - lockup or soft reset: peripherals, security unit, GPIO reset; regulators, retention kept.
// - wakeup resets only ordinary peripheral registers.
// - watchdog and pin also reset regulators; brownout and power-on clear retention too.
// - lockup and soft reset keep the GPIO core-owner selection field.
// - network lockup or soft reset resets only the network CPU.
// - hold-off or either watchdog resets network CPU and watchdog; record kept.
// - pin, brownout and power-on reset the network core like the application core.
// - network peripherals and GPIO per source; hold-off only peripherals; retention never.
// - network core stays held off until software releases the hold-off control.
// - cause flags accumulate; writing one clears, several at once allowed.
module reset_distributor
  import reset_dist_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        app_lockup,
  input  wire logic        app_soft_req,
  input  wire logic        sysoff_wake,
  input  wire logic        app_wdt_timeout,
  input  wire logic        net_lockup,
  input  wire logic        net_soft_req,
  input  wire logic        net_wdt_timeout,
  input  wire logic        pin_reset_n,
  input  wire logic        brownout_det,
  input  wire logic        debug_mode,
  input  wire logic        system_off,
  output logic             app_cpu_rst_n,
  output logic             net_cpu_rst_n,
  output logic             app_debug_rst_n,
  output logic             net_debug_rst_n,
  output logic             app_wdt_rst_n,
  output logic             net_wdt_rst_n,
  output logic             app_periph_rst_n,
  output logic             spu_rst_n,
  output logic             app_gpio_rst_n,
  output logic             gpio_owner_rst_n,
  output logic             regulator_rst_n,
  output logic             gpreg_rst_n,
  output logic             net_periph_rst_n,
  output logic             net_gpio_rst_n,
  output logic             netcore_hold_off,
  output logic             app_wdt_run,
  output logic             net_wdt_run
);

  typedef struct packed {
    logic                pin_s1;
    logic                pin_s2;
    logic                bo_s1;
    logic                bo_s2;
    logic [CNT_W-1:0]    cnt;
    logic [NTGT-1:0]     pend;
    logic [NTGT-1:0]     rst_n;
    logic                hold_off;
    logic                app_wdt_run;
    logic                net_wdt_run;
    logic [31:0]         app_cause;
    logic [31:0]         net_cause;
    logic [GPREG_W-1:0]  gpreg;
    logic                pready;
    logic                pslverr;
    logic [31:0]         prdata;
  } state_t;

  // power-on: every target held in reset, network core held off
  localparam state_t ST_RESET = '{
    pin_s1: 1'b1, pin_s2: 1'b1, bo_s1: 1'b0, bo_s2: 1'b0,
    cnt: PULSE_LOAD, pend: '1, rst_n: '0, hold_off: 1'b1,
    app_wdt_run: 1'b0, net_wdt_run: 1'b0,
    app_cause: RESET_ZERO, net_cause: RESET_ZERO, gpreg: '0,
    pready: 1'b0, pslverr: 1'b0, prdata: RESET_ZERO
  };

  // target set reached by one source, before debug masking
  function automatic logic [NTGT-1:0] src_mask(input int s);
    logic [NTGT-1:0] m;
    m = '0;
    unique case (s)
      S_APP_LOCKUP, S_APP_SOFT: begin
        m[T_APP_CPU]    = 1'b1;
        m[T_NET_CPU]    = 1'b1;
        m[T_APP_PERIPH] = 1'b1;
        m[T_SPU]        = 1'b1;
        m[T_APP_GPIO]   = 1'b1;
      end
      S_WAKE: begin
        m[T_APP_CPU]    = 1'b1;
        m[T_NET_CPU]    = 1'b1;
        m[T_APP_DBG]    = 1'b1;
        m[T_NET_DBG]    = 1'b1;
        m[T_APP_WDT]    = 1'b1;
        m[T_APP_PERIPH] = 1'b1;
      end
      S_APP_WDT, S_PIN, S_BROWNOUT: begin
        m[T_APP_CPU]    = 1'b1;
        m[T_NET_CPU]    = 1'b1;
        m[T_APP_DBG]    = 1'b1;
        m[T_APP_WDT]    = 1'b1;
        m[T_NET_WDT]    = 1'b1;
        m[T_APP_PERIPH] = 1'b1;
        m[T_SPU]        = 1'b1;
        m[T_APP_GPIO]   = 1'b1;
        m[T_GPIO_OWNER] = 1'b1;
        m[T_REGUL]      = 1'b1;
        m[T_NET_PERIPH] = 1'b1;
        m[T_NET_GPIO]   = 1'b1;
        m[T_NET_DBG]    = (s != S_APP_WDT);
        m[T_GPREG]      = (s == S_BROWNOUT);
      end
      S_HOLDOFF: begin
        m[T_NET_CPU]    = 1'b1;
        m[T_NET_WDT]    = 1'b1;
        m[T_NET_PERIPH] = 1'b1;
      end
      S_NET_LOCKUP, S_NET_SOFT: begin
        m[T_NET_CPU]    = 1'b1;
        m[T_NET_PERIPH] = 1'b1;
        m[T_NET_GPIO]   = 1'b1;
      end
      S_NET_WDT: begin
        m[T_NET_CPU]    = 1'b1;
        m[T_NET_WDT]    = 1'b1;
        m[T_NET_PERIPH] = 1'b1;
        m[T_NET_GPIO]   = 1'b1;
      end
      default: m = '0;
    endcase
    return m;
  endfunction : src_mask

  state_t          st_r;
  state_t          st_nxt;
  logic [NSRC-1:0] req;
  logic [NTGT-1:0] hit;
  logic            app_any;
  logic            acc;
  logic            wr_en;
  logic            mapped;
  logic [31:0]     set_app;
  logic [31:0]     set_net;
  logic [31:0]     clr_app;
  logic [31:0]     clr_net;

  // the whole block: sources gated, mapped to targets, pulse timed, bus served
  always_comb begin
    st_nxt  = st_r;
    req     = '0;
    hit     = '0;
    set_app = '0;
    set_net = '0;
    clr_app = '0;
    clr_net = '0;
    // pins cross into pclk; only the second stage is looked at
    st_nxt.pin_s1 = pin_reset_n;
    st_nxt.pin_s2 = st_r.pin_s1;
    st_nxt.bo_s1  = brownout_det;
    st_nxt.bo_s2  = st_r.bo_s1;

    acc    = psel && penable;
    wr_en  = acc && pwrite && st_r.pready;
    mapped = (paddr == OFF_APP_CAUSE) || (paddr == OFF_NET_CAUSE) ||
             (paddr == OFF_HOLD_OFF) || (paddr == OFF_GPREG) || (paddr == OFF_STATUS);

    // source gating
    req[S_APP_LOCKUP] = app_lockup && !debug_mode && !system_off;
    req[S_APP_SOFT]   = app_soft_req;
    req[S_WAKE]       = sysoff_wake;
    req[S_APP_WDT]    = app_wdt_timeout && !system_off;
    req[S_PIN]        = !st_r.pin_s2;
    req[S_BROWNOUT]   = st_r.bo_s2;
    req[S_HOLDOFF]    = wr_en && (paddr == OFF_HOLD_OFF) && pwdata[0] && !st_r.hold_off;
    req[S_NET_LOCKUP] = net_lockup && !debug_mode && !system_off && !st_r.hold_off;
    req[S_NET_SOFT]   = net_soft_req && !st_r.hold_off;
    req[S_NET_WDT]    = net_wdt_timeout && !system_off && !st_r.hold_off;
    app_any = |req[S_BROWNOUT:S_APP_LOCKUP];

    for (int i = 0; i < NSRC; i++) begin
      if (req[i]) begin
        hit = hit | src_mask(i);
      end
    end
    // an application reset also carries the network hold-off reset
    if (app_any) begin
      hit = hit | src_mask(S_HOLDOFF);
    end
    if (debug_mode) begin
      hit[T_APP_DBG] = 1'b0;
      hit[T_NET_DBG] = 1'b0;
    end

    // pulse timer: a fresh request restarts the full width so no target is cut short
    if (hit != '0) begin
      st_nxt.pend = st_r.pend | hit;
      st_nxt.cnt  = PULSE_LOAD;
    end else if (st_r.cnt != '0) begin
      st_nxt.cnt = st_r.cnt - CNT_LAST;
      if (st_r.cnt == CNT_LAST) begin
        st_nxt.pend = '0;
      end
    end

    // hold-off: software write, overridden by any application reset
    if (wr_en && (paddr == OFF_HOLD_OFF)) begin
      st_nxt.hold_off = pwdata[0];
    end
    if (app_any) begin
      st_nxt.hold_off = 1'b1;
    end
    st_nxt.rst_n = ~st_nxt.pend;
    if (st_nxt.hold_off) begin
      st_nxt.rst_n[T_NET_CPU] = 1'b0;
    end
    st_nxt.app_wdt_run = !system_off && st_nxt.rst_n[T_APP_WDT];
    st_nxt.net_wdt_run = !system_off && !st_nxt.hold_off && st_nxt.rst_n[T_NET_WDT];

    // cause record events; application events also show in the network record
    set_app[CB_PIN]     = req[S_PIN];
    set_app[CB_DOG]     = req[S_APP_WDT];
    set_app[CB_SREQ]    = req[S_APP_SOFT];
    set_app[CB_LOCKUP]  = req[S_APP_LOCKUP];
    set_app[CB_OFF]     = req[S_WAKE];
    set_net             = set_app;
    set_net[CB_LSREQ]   = req[S_NET_SOFT];
    set_net[CB_LLOCKUP] = req[S_NET_LOCKUP];
    set_net[CB_LDOG]    = req[S_NET_WDT];
    set_net[CB_HOLDOFF] = app_any || req[S_HOLDOFF];
    if (wr_en && (paddr == OFF_APP_CAUSE)) begin
      clr_app = pwdata;
    end
    if (wr_en && (paddr == OFF_NET_CAUSE)) begin
      clr_net = pwdata;
    end
    // set beats a same-cycle clear; brownout wipes the records and retention
    if (req[S_BROWNOUT]) begin
      st_nxt.app_cause = set_app;
      st_nxt.net_cause = set_net;
      st_nxt.gpreg     = '0;
    end else begin
      st_nxt.app_cause = (st_r.app_cause & ~clr_app) | set_app;
      st_nxt.net_cause = (st_r.net_cause & ~clr_net) | set_net;
      if (wr_en && (paddr == OFF_GPREG)) begin
        st_nxt.gpreg = pwdata[GPREG_W-1:0];
      end
    end

    // apb: one wait state, answer registered in the first access cycle
    st_nxt.pready  = acc && !st_r.pready;
    st_nxt.pslverr = acc && !st_r.pready && !mapped;
    st_nxt.prdata  = RESET_ZERO;
    if (acc && !st_r.pready && !pwrite) begin
      unique case (paddr)
        OFF_APP_CAUSE: st_nxt.prdata = st_r.app_cause;
        OFF_NET_CAUSE: st_nxt.prdata = st_r.net_cause;
        OFF_HOLD_OFF:  st_nxt.prdata[0] = st_r.hold_off;
        OFF_GPREG:     st_nxt.prdata[GPREG_W-1:0] = st_r.gpreg;
        OFF_STATUS: begin
          st_nxt.prdata[ST_BUSY]   = (st_r.cnt != '0);
          st_nxt.prdata[ST_DEBUG]  = debug_mode;
          st_nxt.prdata[ST_SYSOFF] = system_off;
          st_nxt.prdata[ST_HOLD]   = st_r.hold_off;
          st_nxt.prdata[ST_TGT_LSB +: NTGT] = ~st_r.rst_n;
        end
        default: st_nxt.prdata = RESET_ZERO;
      endcase
    end
  end

  // only presetn asserts asynchronously; everything releases on pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // RAM has no clear path at all: no output here writes or wipes memory
  assign prdata           = st_r.prdata;
  assign pready           = st_r.pready;
  assign pslverr          = st_r.pslverr;
  assign app_cpu_rst_n    = st_r.rst_n[T_APP_CPU];
  assign net_cpu_rst_n    = st_r.rst_n[T_NET_CPU];
  assign app_debug_rst_n  = st_r.rst_n[T_APP_DBG];
  assign net_debug_rst_n  = st_r.rst_n[T_NET_DBG];
  assign app_wdt_rst_n    = st_r.rst_n[T_APP_WDT];
  assign net_wdt_rst_n    = st_r.rst_n[T_NET_WDT];
  assign app_periph_rst_n = st_r.rst_n[T_APP_PERIPH];
  assign spu_rst_n        = st_r.rst_n[T_SPU];
  assign app_gpio_rst_n   = st_r.rst_n[T_APP_GPIO];
  assign gpio_owner_rst_n = st_r.rst_n[T_GPIO_OWNER];
  assign regulator_rst_n  = st_r.rst_n[T_REGUL];
  assign gpreg_rst_n      = st_r.rst_n[T_GPREG];
  assign net_periph_rst_n = st_r.rst_n[T_NET_PERIPH];
  assign net_gpio_rst_n   = st_r.rst_n[T_NET_GPIO];
  assign netcore_hold_off = st_r.hold_off;
  assign app_wdt_run      = st_r.app_wdt_run;
  assign net_wdt_run      = st_r.net_wdt_run;

  // checks on the sequencer
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic net_cause_bit_hold;
  assign net_cause_bit_hold = st_r.net_cause[CB_HOLDOFF];

  AST_HOLD_ON_APP_RESET: assert property (
    req[S_APP_SOFT] |=> netcore_hold_off && !net_cpu_rst_n && net_cause_bit_hold)
    else $error("application reset did not hold the network core off");

  AST_APP_WDT_STOP: assert property (
    system_off |=> !app_wdt_run)
    else $error("application watchdog running in system off");

  // hold-off and the run enable are registered together, so they are compared in one cycle
  AST_NET_WDT_STOP: assert property (
    (system_off |=> !net_wdt_run) and (netcore_hold_off |-> !net_wdt_run))
    else $error("network watchdog running while off or held");

  AST_DBG_KEPT: assert property (
    $fell(app_debug_rst_n) || $fell(net_debug_rst_n) |-> !$past(debug_mode))
    else $error("debug logic reset in debug mode");

  // watched at the output: a lone lockup in debug mode must leave the cpu running
  AST_LOCKUP_MUTED: assert property (
    debug_mode && app_lockup && !(|req[S_BROWNOUT:S_APP_SOFT]) && (st_r.cnt == '0)
      |=> app_cpu_rst_n)
    else $error("lockup request passed in debug mode");

  AST_OWNER_KEPT: assert property (
    $fell(gpio_owner_rst_n) |-> $past(req[S_APP_WDT] || req[S_PIN] || req[S_BROWNOUT]))
    else $error("gpio owner select reset by wrong source");

  AST_BROWNOUT_CLEARS: assert property (
    req[S_BROWNOUT] |=> !gpreg_rst_n && !net_cpu_rst_n && (st_r.gpreg == '0))
    else $error("brownout did not clear retention");

  AST_FLAG_SET_WINS: assert property (
    req[S_APP_SOFT] |=> st_r.app_cause[CB_SREQ] ##1 st_r.app_cause[CB_SREQ])
    else $error("soft reset flag lost");

  AST_PULSE_WIDTH: assert property (
    $fell(app_cpu_rst_n) |-> !app_cpu_rst_n [*5])
    else $error("application cpu reset pulse too short");

  AST_HOLD_STAYS: assert property (
    netcore_hold_off && !(wr_en && (paddr == OFF_HOLD_OFF)) |=> netcore_hold_off)
    else $error("hold-off released without software");

  AST_NET_LOCAL: assert property (
    req[S_NET_SOFT] && !app_any && (st_r.cnt == '0) |=> app_cpu_rst_n && !net_cpu_rst_n)
    else $error("network soft reset escaped its core");

  COV_SOFT: cover property (req[S_APP_SOFT] ##1 !app_cpu_rst_n);
  COV_PIN: cover property (req[S_PIN] ##1 !regulator_rst_n);
  COV_RELEASE: cover property ($fell(netcore_hold_off) ##[1:10] net_cpu_rst_n);
  COV_NET_WDT: cover property (req[S_NET_WDT] ##1 !net_wdt_rst_n);

endmodule : reset_distributor
`default_nettype wire

// ---- tb_reset_distributor.sv ----
`default_nettype none
module tb_reset_distributor
  import reset_dist_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic            pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic            debug_mode, system_off, hold, awr, nwr, er;
  logic [11:0]     paddr;
  logic [31:0]     pwdata, prdata, rd;
  logic            al, as, sw, aw, nl, ns, nw, pn, bo;
  logic [NTGT-1:0] rst_n;
  int              fail_count, checked;

  core_model u_core_model (.pclk(pclk), .app_lockup(al), .app_soft_req(as), .sysoff_wake(sw),
    .app_wdt_timeout(aw), .net_lockup(nl), .net_soft_req(ns), .net_wdt_timeout(nw),
    .pin_reset_n(pn), .brownout_det(bo));

  reset_distributor u_reset_distributor (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .app_lockup(al), .app_soft_req(as),
    .sysoff_wake(sw), .app_wdt_timeout(aw), .net_lockup(nl), .net_soft_req(ns),
    .net_wdt_timeout(nw), .pin_reset_n(pn), .brownout_det(bo), .debug_mode(debug_mode),
    .system_off(system_off), .app_cpu_rst_n(rst_n[0]), .net_cpu_rst_n(rst_n[1]),
    .app_debug_rst_n(rst_n[2]), .net_debug_rst_n(rst_n[3]), .app_wdt_rst_n(rst_n[4]),
    .net_wdt_rst_n(rst_n[5]), .app_periph_rst_n(rst_n[6]), .spu_rst_n(rst_n[7]),
    .app_gpio_rst_n(rst_n[8]), .gpio_owner_rst_n(rst_n[9]), .regulator_rst_n(rst_n[10]),
    .gpreg_rst_n(rst_n[11]), .net_periph_rst_n(rst_n[12]), .net_gpio_rst_n(rst_n[13]),
    .netcore_hold_off(hold), .app_wdt_run(awr), .net_wdt_run(nwr));

  // 25 MHz clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic close_out;
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  // one apb transfer; the wait for pready is bounded so a dead slave ends the run
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      $display("MISMATCH pready expected 1 seen timeout");
      close_out();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, rd, exp);
  endtask : rchk

  // fires one source with the network core released, gathers every target it pulsed
  task automatic trig(input int src, input logic [NTGT-1:0] exp);
    logic [NTGT-1:0] seen;
    apb(1'b1, OFF_HOLD_OFF, 32'h0000_0000);
    repeat (3) @(posedge pclk);
    seen = '0;
    u_core_model.pulse(src);
    repeat (9) begin
      @(negedge pclk);
      seen |= ~rst_n;
    end
    chk("targets", 32'(seen), 32'(exp));
    repeat (12) @(posedge pclk);
    chk("hold_off", 32'(hold), 32'(exp[T_APP_CPU]));
    chk("released", 32'(rst_n), exp[T_APP_CPU] ? 32'h3ffd : 32'h3fff);
  endtask : trig

  task automatic t_reset;
    chk("idle", 32'(rst_n), 32'h3ffd);
    chk("hold", 32'(hold), 32'h1);
    chk("net wdt run", 32'(nwr), 32'h0);
    rchk("app cause", OFF_APP_CAUSE, RESET_ZERO);
    rchk("gpreg", OFF_GPREG, RESET_ZERO);
    rchk("hold reg", OFF_HOLD_OFF, 32'h0000_0001);
    rchk("status", OFF_STATUS, 32'h0002_0008);
    rchk("unmapped", 12'h014, RESET_ZERO);
    chk("slverr", 32'(er), 32'h1);
    $display("test reset done");
  endtask : t_reset

  task automatic t_app;
    apb(1'b1, OFF_GPREG, 32'h0000_005a);
    trig(S_APP_SOFT, 14'h11e3);
    rchk("app cause", OFF_APP_CAUSE, 32'h0000_0008);
    rchk("net cause", OFF_NET_CAUSE, 32'h0100_0008);
    trig(S_APP_LOCKUP, 14'h11e3);
    rchk("app accum", OFF_APP_CAUSE, 32'h0000_0018);
    apb(1'b1, OFF_APP_CAUSE, 32'h0000_0018);
    rchk("app w1c", OFF_APP_CAUSE, RESET_ZERO);
    trig(S_WAKE, 14'h107f);
    rchk("gpreg kept", OFF_GPREG, 32'h0000_005a);
    $display("test app sources done");
  endtask : t_app

  task automatic t_sys;
    apb(1'b1, OFF_APP_CAUSE, 32'hffff_ffff);
    trig(S_APP_WDT, 14'h37f7);
    trig(S_PIN, 14'h37ff);
    rchk("app cause", OFF_APP_CAUSE, 32'h0000_0003);
    rchk("gpreg pin", OFF_GPREG, 32'h0000_005a);
    trig(S_BROWNOUT, 14'h3fff);
    rchk("cause cleared", OFF_APP_CAUSE, RESET_ZERO);
    rchk("gpreg cleared", OFF_GPREG, RESET_ZERO);
    $display("test system sources done");
  endtask : t_sys

  task automatic t_net;
    apb(1'b1, OFF_NET_CAUSE, 32'hffff_ffff);
    trig(S_NET_LOCKUP, 14'h3002);
    trig(S_NET_SOFT, 14'h3002);
    trig(S_NET_WDT, 14'h3022);
    rchk("net cause", OFF_NET_CAUSE, 32'h0007_0000);
    chk("net wdt run", 32'(nwr), 32'h1);
    apb(1'b1, OFF_HOLD_OFF, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk("holdoff net", 32'(rst_n[T_NET_CPU]), 32'h0);
    chk("holdoff app", 32'(rst_n[T_APP_CPU]), 32'h1);
    chk("held wdt run", 32'(nwr), 32'h0);
    $display("test network sources done");
  endtask : t_net

  task automatic t_mode;
    debug_mode <= 1'b1;
    trig(S_APP_LOCKUP, 14'h0000);
    trig(S_NET_LOCKUP, 14'h0000);
    trig(S_PIN, 14'h37f3);
    debug_mode <= 1'b0;
    system_off <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("off app wdt", 32'(awr), 32'h0);
    chk("off net wdt", 32'(nwr), 32'h0);
    trig(S_APP_LOCKUP, 14'h0000);
    trig(S_APP_WDT, 14'h0000);
    trig(S_NET_WDT, 14'h0000);
    system_off <= 1'b0;
    $display("test modes done");
  endtask : t_mode

  // a second power-on reset in mid-run: targets fall at once, rise on the 5th edge
  task automatic t_por;
    @(posedge pclk);
    presetn <= 1'b0;
    #1;
    chk("async assert", 32'(rst_n), 32'h0);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    #1;
    chk("still held", 32'(rst_n), 32'h0);
    @(posedge pclk);
    #1;
    chk("sync release", 32'(rst_n), 32'h3ffd);
    $display("test power-on done");
  endtask : t_por

  // main sequence
  initial begin
    fail_count = 0;
    checked = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, debug_mode, system_off} = '0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (7) @(posedge pclk);
    t_reset();
    t_app();
    t_sys();
    t_net();
    t_mode();
    t_por();
    close_out();
  end
endmodule : tb_reset_distributor
`default_nettype wire
